// ===== shared/lps_pkg.sv
// Purpose: shared constants and types of the resonant controller sequencer
// Assumes: 125 MHz reference clock
// Notes:   times are kept in their own unit, cycle counts are derived
package lps_pkg;
	localparam int CLK_PERIOD_NS   = 8;
	// mains blanking, selection charge and enable-pin blanking, in microseconds
	localparam int T_MAINS_OUT_US  = 450;
	localparam int T_MAINS_IN_US   = 47;
	localparam int T_SELECT_US     = 26;
	localparam int T_EN_BLANK_US   = 320;
	localparam int T_SR_DELAY_NS   = 250;
	localparam int MAINS_OUT_CYC   = (T_MAINS_OUT_US * 1000) / CLK_PERIOD_NS;
	localparam int MAINS_IN_CYC    = (T_MAINS_IN_US * 1000) / CLK_PERIOD_NS;
	localparam int SELECT_CYC      = (T_SELECT_US * 1000) / CLK_PERIOD_NS;
	localparam int EN_BLANK_CYC    = (T_EN_BLANK_US * 1000) / CLK_PERIOD_NS;
	localparam int SR_DELAY_CYC    = (T_SR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// rectifier soft ramp, on-time in seventieths of the full value
	localparam int RAMP_STEP_CYCLES = 16;
	localparam int RAMP_TOTAL       = 128;
	localparam logic [6:0] RAMP_BASE = 7'h07;
	localparam logic [6:0] RAMP_INC  = 7'h09;
	localparam logic [6:0] RAMP_FULL = 7'h46;
	// register port
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam int CTRL_SR_EN_BIT     = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// comparator results, as seen on the pins
	typedef struct packed {
		logic supply_on;
		logic mains_ok;
		logic mains_hi;
		logic overload;
		logic timer_hi;
		logic timer_lo;
		logic enable_hi;
		logic burst_low;
		logic burst_high;
	} lps_cmp_t;
	typedef enum logic [0:0] {OL_RUN, OL_SHUT} lps_ol_t;
	typedef enum logic [1:0] {SEL_WAIT, SEL_CHARGE, SEL_BLANK, SEL_DONE} lps_sel_t;
endpackage : lps_pkg

// ===== core/lps_sequencer.sv
// Purpose: protection, soft ramp and burst selection sequencing
// Assumes: resetn is the supply power-on reset; events are one-cycle pulses
// Notes:   analog sources are driven by the enable outputs only
// Notes on behaviour
// - first rectifier on-time one tenth, 16 cycles
// - seven steps of 16 cycles, full after 112
// - mains detector blanked 450 us out, 47 us in
// - mains-high result selects rectifier turn-on delay
// - rectifier gate rises 250 ns after primary
// - overload beyond blanking forces all gates off
// - restart only after restart time, with soft start
// - timer charge on overload, off at trip
// - timer upper trip turns all gates off
// - timer below lower level restarts with soft start
// - enable pin low in operation latches stop
// - stop latch cleared only by power-on reset
// - burst selection runs once after first supply-on
// - selection source added to enable-pin source
// - sample enable pin once 26 us later
// - burst stop only when burst mode selected
// - selection source off right after sample
// - enable pin ignored 320 us after selection
// - burst stop after high-side cycle, resume above
`timescale 1ns/10ps
`default_nettype none
module lps_sequencer
	import lps_pkg::*;
#(
	parameter int MAINS_OUT_CYCLES = MAINS_OUT_CYC,
	parameter int MAINS_IN_CYCLES  = MAINS_IN_CYC,
	parameter int EN_BLANK_CYCLES  = EN_BLANK_CYC
) (
	// clock and power-on reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// comparator results and switching events
	input  wire lps_cmp_t   cmp_raw,
	input  wire logic       cycle_start,
	input  wire logic       hs_cycle_end,
	input  wire logic [1:0] pri_rise,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// gate and source controls
	output logic            gate_enable,
	output logic            sr_gate_enable,
	output logic      [6:0] sr_on_frac,
	output logic      [1:0] sr_rise,
	output logic            timer_charge_current,
	output logic            selection_current,
	output logic            enable_pin_current,
	output logic            burst_operation,
	output logic            soft_start_req,
	output logic            overload_protect,
	output logic            latched_off
);
	localparam int CW = 17;
	localparam int NC = $bits(lps_cmp_t);
	localparam int SEL_LAST = SELECT_CYC - 1;

	initial begin
		if (MAINS_OUT_CYCLES < 1 || MAINS_OUT_CYCLES >= (1 << CW) ||
		    MAINS_IN_CYCLES < 1 || MAINS_IN_CYCLES >= (1 << CW) ||
		    EN_BLANK_CYCLES < 1 || EN_BLANK_CYCLES >= (1 << CW))
			$error("blanking count out of counter range");
	end

	// two flops per comparator; stage one feeds stage two only
	logic [NC-1:0] sync1_reg;
	logic [NC-1:0] sync2_reg;
	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= cmp_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate
	lps_cmp_t cs;
	assign cs = lps_cmp_t'(sync2_reg);

	// register port: one control, one status
	logic [7:0] ctrl_reg;
	logic       sr_enable;
	assign sr_enable = ctrl_reg[CTRL_SR_EN_BIT];
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) ctrl_reg <= CTRL_RESET;
		else if (reg_wr && reg_addr == CTRL_OFS) ctrl_reg <= reg_wdata;
	end

	// mains brown-out qualifier; the window to cross depends on the present state
	logic          mains_ok_reg;
	logic [CW-1:0] mains_cnt_reg;
	logic [CW-1:0] mains_last;
	logic          mains_diff;
	assign mains_last = mains_ok_reg ? CW'(MAINS_IN_CYCLES - 1) : CW'(MAINS_OUT_CYCLES - 1);
	assign mains_diff = cs.mains_ok != mains_ok_reg;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mains_ok_reg  <= 1'b0;
			mains_cnt_reg <= '0;
		end else if (!mains_diff) begin
			mains_cnt_reg <= '0;
		end else if (mains_cnt_reg == mains_last) begin
			mains_ok_reg  <= cs.mains_ok;
			mains_cnt_reg <= '0;
		end else begin
			mains_cnt_reg <= mains_cnt_reg + 1'b1;
		end
	end

	// burst selection, runs once per power-on since nothing returns to wait
	lps_sel_t      sel_reg;
	lps_sel_t      sel_next;
	logic [CW-1:0] sel_cnt_reg;
	logic          sel_end;
	logic          burst_en_reg;
	assign sel_end = (sel_reg == SEL_CHARGE) ? (sel_cnt_reg == CW'(SEL_LAST)) :
	                 (sel_cnt_reg == CW'(EN_BLANK_CYCLES - 1));
	always_comb begin
		sel_next = sel_reg;
		case (sel_reg)
			SEL_WAIT:   if (cs.supply_on) sel_next = SEL_CHARGE;
			SEL_CHARGE: if (sel_end) sel_next = SEL_BLANK;
			SEL_BLANK:  if (sel_end) sel_next = SEL_DONE;
			default:    sel_next = SEL_DONE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg      <= SEL_WAIT;
			sel_cnt_reg  <= '0;
			burst_en_reg <= 1'b0;
		end else begin
			sel_reg     <= sel_next;
			sel_cnt_reg <= (sel_next != sel_reg) ? '0 : sel_cnt_reg + 1'b1;
			if (sel_reg == SEL_CHARGE && sel_end) burst_en_reg <= cs.enable_hi;
		end
	end

	// overload timer state; the capacitor itself times blanking and restart
	lps_ol_t ol_reg;
	lps_ol_t ol_next;
	logic    ol_restart;
	assign ol_restart = (ol_reg == OL_SHUT) && cs.timer_lo;
	always_comb begin
		ol_next = ol_reg;
		case (ol_reg)
			OL_RUN:  if (cs.timer_hi) ol_next = OL_SHUT;
			default: if (cs.timer_lo) ol_next = OL_RUN;
		endcase
	end

	// stop latch and burst pause
	logic latch_next;
	logic burst_idle_reg;
	logic burst_idle_next;
	logic run_next;
	assign latch_next = latched_off || (sel_reg == SEL_DONE && !cs.enable_hi);
	assign burst_idle_next = !burst_en_reg ? 1'b0 :
	                         burst_idle_reg ? !cs.burst_high :
	                         (cs.burst_low && hs_cycle_end);
	assign run_next = mains_ok_reg && ol_next == OL_RUN && !latch_next &&
	                  !burst_idle_next && (sel_reg == SEL_BLANK || sel_reg == SEL_DONE);

	// rectifier soft ramp, counted in switching cycles
	logic [6:0] ramp_cnt_reg;
	logic [6:0] ramp_cnt_next;
	logic       ramp_done_reg;
	logic       ramp_done_next;
	logic       sr_next;
	logic [2:0] ramp_level;
	logic [6:0] frac_next;
	assign sr_next = sr_enable && run_next;
	assign ramp_done_next = sr_next && (ramp_done_reg ||
	                        (sr_gate_enable && cycle_start && ramp_cnt_reg == 7'(RAMP_TOTAL - 1)));
	assign ramp_cnt_next = !sr_next ? 7'h00 :
	                       (sr_gate_enable && cycle_start && !ramp_done_reg &&
	                        ramp_cnt_reg != 7'(RAMP_TOTAL - 1)) ? ramp_cnt_reg + 7'h01 :
	                       ramp_cnt_reg;
	// level changes every sixteen cycles; the last level is the full value
	assign ramp_level = ramp_done_next ? 3'h7 : ramp_cnt_next[6:4];
	assign frac_next = RAMP_BASE + 7'(ramp_level * RAMP_INC);

	// rectifier turn-on delay per side, only when mains is high
	logic [5:0] dly_cnt_reg [2];
	logic [1:0] rise_next;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_dly
			assign rise_next[gi] = sr_gate_enable && ((pri_rise[gi] && !cs.mains_hi) ||
			                       dly_cnt_reg[gi] == 6'h01);
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) dly_cnt_reg[gi] <= 6'h00;
				else if (!sr_gate_enable) dly_cnt_reg[gi] <= 6'h00;
				else if (pri_rise[gi] && cs.mains_hi) dly_cnt_reg[gi] <= 6'(SR_DELAY_CYC);
				else if (dly_cnt_reg[gi] != 6'h00) dly_cnt_reg[gi] <= dly_cnt_reg[gi] - 6'h01;
			end
		end
	endgenerate

	// all outputs from flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ol_reg               <= OL_RUN;
			burst_idle_reg       <= 1'b0;
			ramp_cnt_reg         <= 7'h00;
			ramp_done_reg        <= 1'b0;
			gate_enable          <= 1'b0;
			sr_gate_enable       <= 1'b0;
			sr_on_frac           <= RAMP_BASE;
			sr_rise              <= 2'b00;
			timer_charge_current <= 1'b0;
			selection_current    <= 1'b0;
			enable_pin_current   <= 1'b0;
			burst_operation      <= 1'b0;
			soft_start_req       <= 1'b0;
			overload_protect     <= 1'b0;
			latched_off          <= 1'b0;
			reg_rdata            <= 8'h00;
		end else begin
			ol_reg               <= ol_next;
			burst_idle_reg       <= burst_idle_next;
			ramp_cnt_reg         <= ramp_cnt_next;
			ramp_done_reg        <= ramp_done_next;
			gate_enable          <= run_next;
			sr_gate_enable       <= sr_next;
			sr_on_frac           <= frac_next;
			sr_rise              <= rise_next;
			// charge off at the trip and whenever feedback drops
			timer_charge_current <= ol_next == OL_RUN && cs.overload && !cs.timer_hi;
			selection_current    <= sel_next == SEL_CHARGE;
			enable_pin_current   <= sel_next != SEL_WAIT;
			burst_operation      <= burst_en_reg;
			soft_start_req       <= ol_restart;
			overload_protect     <= ol_next == OL_SHUT;
			latched_off          <= latch_next;
			// read data valid only in the cycle after the strobe
			if (reg_rd && reg_addr == CTRL_OFS) reg_rdata <= ctrl_reg;
			else if (reg_rd && reg_addr == STATUS_OFS)
				reg_rdata <= {ramp_done_reg, burst_idle_reg, burst_en_reg, latched_off,
				              ol_reg == OL_SHUT, mains_ok_reg, sr_gate_enable, gate_enable};
			else reg_rdata <= 8'h00;
		end
	end

	AST_RAMP_FIRST: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sr_gate_enable && !ramp_done_reg && ramp_cnt_reg < 7'h10) |-> sr_on_frac == RAMP_BASE)
		else $error("first ramp level is not one tenth");
	AST_RAMP_FULL: assert property (@(posedge ref_clk) disable iff (!resetn)
		ramp_done_reg |-> sr_on_frac == RAMP_FULL && sr_gate_enable)
		else $error("ramp done without full on-time");
	AST_RAMP_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sr_gate_enable && cycle_start && !ramp_done_reg && ramp_cnt_reg[3:0] == 4'hf &&
		 ramp_cnt_reg != 7'h7f && sr_next) |=> sr_on_frac == $past(sr_on_frac) + RAMP_INC)
		else $error("ramp increment wrong");
	AST_MAINS_OUT: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(mains_ok_reg) |-> $past(mains_cnt_reg) == CW'(MAINS_OUT_CYCLES - 1))
		else $error("mains left brown-out without full blanking");
	sequence s_trip;
		ol_reg == OL_RUN && cs.timer_hi;
	endsequence
	AST_OL_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_trip |=> !gate_enable && !sr_gate_enable && overload_protect && !timer_charge_current)
		else $error("gates not off after overload trip");
	sequence s_recover;
		ol_reg == OL_SHUT && cs.timer_lo;
	endsequence
	AST_OL_RESTART: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_recover |=> soft_start_req ##1 !soft_start_req)
		else $error("restart without soft start pulse");
	AST_LATCH: assert property (@(posedge ref_clk) disable iff (!resetn)
		latched_off |=> latched_off && !gate_enable)
		else $error("stop latch released");
	AST_SEL_TIME: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(selection_current) |-> $past(sel_cnt_reg) == CW'(SEL_LAST))
		else $error("selection source on for wrong time");
	AST_BURST_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		!burst_en_reg |-> !burst_idle_reg)
		else $error("burst pause without burst mode");
	AST_SR_DELAY: assert property (@(posedge ref_clk) disable iff (!resetn)
		(pri_rise[0] && cs.mains_hi && sr_gate_enable && sr_next) |-> !sr_rise[0] [*8])
		else $error("rectifier rose before turn-on delay");
	// brown-out entry, charge source and the stop latch with its blanking
	AST_MAINS_IN: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(mains_ok_reg) |-> $past(mains_cnt_reg) == CW'(MAINS_IN_CYCLES - 1))
		else $error("mains entered brown-out without full blanking");
	AST_CHARGE_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		(cs.timer_hi || !cs.overload) |=> !timer_charge_current)
		else $error("timer charge source left on");
	AST_LATCH_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sel_reg == SEL_DONE && !cs.enable_hi) |=> latched_off && !gate_enable)
		else $error("enable pin low did not latch stop");
	AST_SEL_BLANK: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sel_reg != SEL_DONE && !latched_off) |=> !latched_off)
		else $error("stop latched during selection blanking");
endmodule : lps_sequencer
`default_nettype wire

// ===== test/lps_sequencer_tb.sv
// Purpose: self-checking bench of the sequencer through its ports
// Assumes: shortened blanking counts, inputs change by nba on the rising edge
// Notes:   waits are bounded; exact counts only where the hand-over fixes them
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import lps_pkg::*;
	logic        ref_clk, resetn, cycle_start, hs_cycle_end, reg_wr, reg_rd;
	logic [1:0]  pri_rise, sr_rise;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [6:0]  sr_on_frac;
	logic        gate_enable, sr_gate_enable, timer_charge_current, selection_current;
	logic        enable_pin_current, burst_operation, soft_start_req, overload_protect;
	logic        latched_off;
	lps_cmp_t    cmp;
	logic [10:0] mon;
	int          checks, miscompares, n, k;

	lps_sequencer #(.MAINS_OUT_CYCLES(40), .MAINS_IN_CYCLES(10), .EN_BLANK_CYCLES(20)) i_dut (
		.ref_clk(ref_clk), .resetn(resetn), .cmp_raw(cmp), .cycle_start(cycle_start),
		.hs_cycle_end(hs_cycle_end), .pri_rise(pri_rise), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gate_enable(gate_enable), .sr_gate_enable(sr_gate_enable), .sr_on_frac(sr_on_frac),
		.sr_rise(sr_rise), .timer_charge_current(timer_charge_current),
		.selection_current(selection_current), .enable_pin_current(enable_pin_current),
		.burst_operation(burst_operation), .soft_start_req(soft_start_req),
		.overload_protect(overload_protect), .latched_off(latched_off));

	// outputs gathered by index so one bounded wait serves them all
	assign mon = {sr_rise, latched_off, overload_protect, soft_start_req, burst_operation,
		enable_pin_current, selection_current, timer_charge_current, sr_gate_enable, gate_enable};

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// sample one cycle at a time until the level shows or the limit runs out
	task automatic wait_for(input int i, input logic v, input int lim, output int c);
		#1;
		c = 0;
		while (mon[i] !== v && c < lim) begin
			@(posedge ref_clk);
			#1;
			c++;
		end
	endtask : wait_for

	task automatic reg_write(input logic [3:0] a, input logic [7:0] w);
		@(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w; end
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [7:0] r);
		@(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask : reg_read

	// one-cycle event pulse: {hs_cycle_end, cycle_start, pri_rise}
	task automatic ev(input logic [3:0] v);
		@(posedge ref_clk) {hs_cycle_end, cycle_start, pri_rise} <= v;
		@(posedge ref_clk) {hs_cycle_end, cycle_start, pri_rise} <= 4'h0;
	endtask : ev

	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// a hang is cut short well beyond the longest expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		test_done;
	end

	initial begin
		{resetn, cycle_start, hs_cycle_end, reg_wr, reg_rd} = 5'h00;
		{pri_rise, reg_addr, reg_wdata} = 14'h0000;
		cmp = '0;
		checks = 0;
		miscompares = 0;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		#1 `CHK("reset frac", RAMP_BASE, sr_on_frac)
		`CHK("reset gate", 1'b0, gate_enable)
		reg_write(CTRL_OFS, 8'h01);
		reg_read(CTRL_OFS, d);
		`CHK("ctrl", 8'h01, d)
		reg_write(4'h8, 8'hff);
		reg_read(4'h8, d);
		`CHK("unmapped", 8'h00, d)
		$display("test registers done");
		// selection: source on for the charge time, sample once, then off
		@(posedge ref_clk) begin cmp.supply_on <= 1'b1; cmp.enable_hi <= 1'b1; end
		wait_for(3, 1'b1, 20, n);
		`CHK("sel on", 1'b1, selection_current)
		`CHK("pin src", 1'b1, enable_pin_current)
		wait_for(3, 1'b0, 4000, n);
		`CHK("sel len", SELECT_CYC, n)
		`CHK("sel off", 1'b0, selection_current)
		@(posedge ref_clk);
		#1 `CHK("burst sel", 1'b1, burst_operation)
		@(posedge ref_clk) cmp.supply_on <= 1'b0;
		repeat (5) @(posedge ref_clk);
		cmp.supply_on <= 1'b1;
		wait_for(3, 1'b1, 50, n);
		`CHK("no resel", 1'b0, selection_current)
		$display("test selection done");
		// mains blanking both ways
		@(posedge ref_clk) cmp.mains_ok <= 1'b1;
		wait_for(0, 1'b1, 200, n);
		`CHK("mains out", 1'b1, n >= 40 && gate_enable === 1'b1)
		@(posedge ref_clk) cmp.mains_ok <= 1'b0;
		wait_for(0, 1'b0, 100, n);
		`CHK("mains in", 1'b1, n >= 10 && gate_enable === 1'b0)
		@(posedge ref_clk) cmp.mains_ok <= 1'b1;
		wait_for(1, 1'b1, 200, n);
		`CHK("sr on", 1'b1, sr_gate_enable)
		$display("test mains done");
		// ramp: eight levels of sixteen switching cycles in equal steps
		for (k = 0; k < 8; k++) begin
			`CHK("ramp", 7'(RAMP_BASE + k * RAMP_INC), sr_on_frac)
			repeat (16) ev(4'h4);
			#1;
		end
		`CHK("ramp full", RAMP_FULL, sr_on_frac)
		$display("test ramp done");
		// rectifier turn-on delay chosen by the mains-high result
		@(posedge ref_clk) cmp.mains_hi <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ev(4'h1);
		wait_for(9, 1'b1, 60, n);
		`CHK("delay", 1'b1, n >= SR_DELAY_CYC && n <= SR_DELAY_CYC + 3)
		@(posedge ref_clk) cmp.mains_hi <= 1'b0;
		repeat (4) @(posedge ref_clk);
		ev(4'h2);
		wait_for(10, 1'b1, 60, n);
		`CHK("no delay", 1'b1, n <= 2)
		$display("test delay done");
		// burst pause waits for the end of the high-side cycle
		@(posedge ref_clk) cmp.burst_low <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 `CHK("burst hold", 1'b1, gate_enable)
		ev(4'h8);
		wait_for(0, 1'b0, 6, n);
		`CHK("burst stop", 1'b0, gate_enable)
		@(posedge ref_clk) begin cmp.burst_low <= 1'b0; cmp.burst_high <= 1'b1; end
		wait_for(0, 1'b1, 8, n);
		`CHK("burst go", 1'b1, gate_enable)
		@(posedge ref_clk) cmp.burst_high <= 1'b0;
		$display("test burst done");
		// overload: charge, trip, restart through soft start
		@(posedge ref_clk) cmp.overload <= 1'b1;
		wait_for(2, 1'b1, 6, n);
		`CHK("charge", 1'b1, timer_charge_current)
		@(posedge ref_clk) cmp.timer_hi <= 1'b1;
		wait_for(0, 1'b0, 6, n);
		`CHK("trip lat", 3, n)
		`CHK("ol state", 1'b1, overload_protect)
		`CHK("charge off", 1'b0, timer_charge_current)
		@(posedge ref_clk) begin cmp.overload <= 1'b0; cmp.timer_hi <= 1'b0; end
		repeat (10) @(posedge ref_clk);
		#1 `CHK("ol wait", 1'b0, gate_enable)
		@(posedge ref_clk) cmp.timer_lo <= 1'b1;
		wait_for(6, 1'b1, 8, n);
		`CHK("soft start", 1'b1, soft_start_req)
		wait_for(7, 1'b0, 4, n);
		`CHK("ol clear", 1'b0, overload_protect)
		@(posedge ref_clk) cmp.timer_lo <= 1'b0;
		wait_for(0, 1'b1, 10, n);
		`CHK("resume", 1'b1, gate_enable)
		$display("test overload done");
		// external stop latches until a new power-on reset
		@(posedge ref_clk) cmp.enable_hi <= 1'b0;
		wait_for(8, 1'b1, 8, n);
		`CHK("latch", 1'b1, latched_off)
		wait_for(0, 1'b0, 4, n);
		`CHK("latch gate", 1'b0, gate_enable)
		@(posedge ref_clk) cmp.enable_hi <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1 `CHK("latch hold", 1'b1, latched_off)
		reg_read(STATUS_OFS, d);
		`CHK("status", 8'h34, d)
		@(posedge ref_clk);
		#1 `CHK("rd clear", 8'h00, reg_rdata)
		@(posedge ref_clk) resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		#1 `CHK("latch clr", 1'b0, latched_off)
		$display("test latch done");
		// new power-on: low pin at the sample, latch hidden by the blanking
		@(posedge ref_clk) cmp.enable_hi <= 1'b0;
		wait_for(3, 1'b1, 20, n);
		wait_for(3, 1'b0, 4000, n);
		`CHK("sel len again", SELECT_CYC, n)
		repeat (10) @(posedge ref_clk);
		#1 `CHK("blank", 1'b0, latched_off)
		`CHK("burst unsel", 1'b0, burst_operation)
		@(posedge ref_clk) begin cmp.enable_hi <= 1'b1; cmp.burst_low <= 1'b1; end
		repeat (4) @(posedge ref_clk);
		ev(4'h8);
		repeat (24) @(posedge ref_clk);
		#1 `CHK("no burst stop", 1'b1, gate_enable)
		`CHK("no latch", 1'b0, latched_off)
		$display("test power cycle done");
		test_done;
	end
endmodule : testbench
`default_nettype wire
